// [fmt_regs.svh]
// Register offsets, field positions and reset values of the mode-control block
`ifndef FMT_REGS_SVH
`define FMT_REGS_SVH
`define FMT_OFF_MODE 12'h000
`define FMT_OFF_CHAN 12'h004
`define FMT_OFF_STAT 12'h008
`define FMT_OFF_IRQ_STAT 12'h00c
`define FMT_OFF_IRQ_MASK 12'h010
`define FMT_BIT_RXREQ 7
`define FMT_BIT_TXREQ 6
`define FMT_BIT_SCAN 5
`define FMT_BIT_STNBY 4
`define FMT_BIT_RXDA 3
`define FMT_BIT_TXDA 2
`define FMT_BIT_RDS 1
`define FMT_BIT_OVR 0
`define FMT_MODE_RESET 8'h01
`define FMT_MODE_WO_MASK 8'hdf
`define FMT_CHAN_RESET 10'h000
`define FMT_THR_RESET 8'h00
`define FMT_IRQ_W 3
`define FMT_IRQ_SCAN_DONE 0
`define FMT_IRQ_MODE_CHG 1
`define FMT_IRQ_SCAN_FOUND 2
`define FMT_CHAN_MAX 10'h3ff
`define FMT_MODE_W 3
`endif

// [fmt_pkg.sv]
// Types shared by the mode-control block
package fmt_pkg;
  typedef enum logic [2:0] {
    FMT_IDLE,
    FMT_STANDBY,
    FMT_RX,
    FMT_TX
  } fmt_mode_e;
  typedef struct packed {
    logic rx_req;
    logic tx_req;
    logic scan_en;
    logic stnby_req;
    logic rx_digital_audio_select;
    logic tx_digital_audio;
    logic rds_en;
    logic scan_result_override;
  } fmt_mode_s;
  typedef struct packed {
    logic valid;
    logic [9:0] index;
    logic [7:0] rssi;
  } fmt_scan_s;
endpackage

// [fmt_scan.sv]
// Channel scan engine: receive stops on first station, transmit keeps the weakest
`timescale 1ns/10ps
`include "fmt_regs.svh"
module fmt_scan_engine
  import fmt_pkg::*;
#(
  parameter int CHW = 10
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic is_tx,
  input wire logic [7:0] tx_scan_threshold,
  // Measurement
  input wire fmt_pkg::fmt_scan_s meas,
  // Result
  output logic [CHW-1:0] probe_index,
  output logic busy,
  output logic done,
  output logic found,
  output logic [CHW-1:0] best_index
);
  import fmt_pkg::*;
  logic [7:0] best_rssi_reg;
  logic last_ch;
  assign last_ch = (probe_index == CHW'(`FMT_CHAN_MAX));

  always_ff @(posedge clock) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      found <= 1'b0;
      probe_index <= '0;
      best_index <= '0;
      best_rssi_reg <= 8'hff;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        found <= 1'b0;
        probe_index <= '0;
        best_rssi_reg <= 8'hff;
      end else if (busy && meas.valid) begin
        if (!is_tx) begin
          if (meas.rssi != 8'h00) begin
            best_index <= probe_index;
            found <= 1'b1;
            busy <= 1'b0;
            done <= 1'b1;
          end
        end else if (meas.rssi < best_rssi_reg &&
                     (tx_scan_threshold == 8'h00 || meas.rssi < tx_scan_threshold)) begin
          best_rssi_reg <= meas.rssi;
          best_index <= probe_index;
          found <= 1'b1;
        end
        if (busy && (is_tx || meas.rssi == 8'h00)) begin
          if (last_ch) begin
            busy <= 1'b0;
            done <= 1'b1;
          end else begin
            probe_index <= probe_index + 1'b1;
          end
        end
      end
    end
  end

  a_scan_done_ends: assert property (@(posedge clock) disable iff (rst)
    done |-> !busy) else $error("scan still busy after done");
endmodule // fmt_scan_engine

// [fmt_mode_ctrl.sv]
// Mode-control register bank with APB slave, mode FSM and scan control
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`include "fmt_regs.svh"
//////////////////////////////////////////////////////////////////////////////
module fmt_mode_ctrl
  import fmt_pkg::*;
#(
  parameter int CHW = 10
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurement from the RF front end
  input wire fmt_pkg::fmt_scan_s meas,
  // Device controls
  output logic rx_on,
  output logic tx_on,
  output logic standby_on,
  output logic rx_audio_digital,
  output logic rx_audio_analog,
  output logic [CHW-1:0] tuned_frequency_index,
  output logic irq
);
  import fmt_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  fmt_mode_s mode_control_reg;
  logic [CHW-1:0] chan_reg;
  logic [7:0] thr_reg;
  logic [`FMT_IRQ_W-1:0] irq_stat_reg;
  logic [`FMT_IRQ_W-1:0] irq_mask_reg;
  fmt_mode_e state_reg;
  fmt_mode_e state_next;
  fmt_mode_e state_d1_reg;
  logic scan_run_reg;
  logic scan_tx_reg;

  logic setup;
  logic wr_acc;
  logic [`FMT_IRQ_W-1:0] irq_events;
  logic irq_pending;
  logic [CHW-1:0] probe_index;
  logic scan_busy;
  logic scan_done;
  logic scan_found;
  logic [CHW-1:0] scan_index;
  logic scan_start;

  function automatic logic addr_known(input logic [11:0] a);
    return a == `FMT_OFF_MODE || a == `FMT_OFF_CHAN || a == `FMT_OFF_STAT ||
           a == `FMT_OFF_IRQ_STAT || a == `FMT_OFF_IRQ_MASK;
  endfunction

  // APB answers in the access cycle following setup (no wait state)
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite;

  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !addr_known(paddr);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (paddr)
        `FMT_OFF_MODE: prdata <= {24'h000000, mode_control_reg};
        `FMT_OFF_CHAN: prdata <= {14'h0000, thr_reg, chan_reg};
        `FMT_OFF_STAT: prdata <= {16'h0000, scan_index, 1'b0, scan_found, scan_run_reg, 3'(state_reg)};
        `FMT_OFF_IRQ_STAT: prdata <= {29'h0, irq_stat_reg};
        `FMT_OFF_IRQ_MASK: prdata <= {29'h0, irq_mask_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode register: request bits written by host, scan enable cleared on completion
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_control_reg <= `FMT_MODE_RESET;
    end else begin
      if (wr_acc && paddr == `FMT_OFF_MODE) begin
        mode_control_reg <= pwdata[7:0];
      end
      if (scan_done && !(wr_acc && paddr == `FMT_OFF_MODE && pwdata[`FMT_BIT_SCAN])) begin
        mode_control_reg.scan_en <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      chan_reg <= CHW'(`FMT_CHAN_RESET);
      thr_reg <= `FMT_THR_RESET;
    end else if (wr_acc && paddr == `FMT_OFF_CHAN) begin
      chan_reg <= pwdata[CHW-1:0];
      thr_reg <= pwdata[CHW+7:CHW];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode state machine
  always_comb begin
    state_next = FMT_IDLE;
    if (mode_control_reg.rx_req) begin
      state_next = FMT_RX;
    end else if (mode_control_reg.tx_req) begin
      state_next = FMT_TX;
    end else if (mode_control_reg.stnby_req && (state_reg == FMT_IDLE || state_reg == FMT_STANDBY)) begin
      state_next = FMT_STANDBY;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= FMT_IDLE;
      state_d1_reg <= FMT_IDLE;
    end else begin
      state_reg <= state_next;
      state_d1_reg <= state_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_on <= 1'b0;
      tx_on <= 1'b0;
      standby_on <= 1'b0;
      rx_audio_digital <= 1'b0;
      rx_audio_analog <= 1'b0;
    end else begin
      case (state_next)
        FMT_RX: begin
          rx_on <= 1'b1;
          tx_on <= 1'b0;
          standby_on <= 1'b0;
        end
        FMT_TX: begin
          rx_on <= 1'b0;
          tx_on <= 1'b1;
          standby_on <= 1'b0;
        end
        FMT_STANDBY: begin
          rx_on <= 1'b0;
          tx_on <= 1'b0;
          standby_on <= 1'b1;
        end
        default: begin
          rx_on <= 1'b0;
          tx_on <= 1'b0;
          standby_on <= 1'b0;
        end
      endcase
      rx_audio_digital <= (state_next == FMT_RX) && mode_control_reg.rx_digital_audio_select;
      rx_audio_analog <= (state_next == FMT_RX) && !mode_control_reg.rx_digital_audio_select;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Scan control
  assign scan_start = mode_control_reg.scan_en && !scan_run_reg &&
                      (state_next == FMT_RX || state_next == FMT_TX);

  always_ff @(posedge clock) begin
    if (rst) begin
      scan_run_reg <= 1'b0;
    end else if (scan_start) begin
      scan_run_reg <= 1'b1;
    end else if (scan_done) begin
      scan_run_reg <= 1'b0;
    end
  end

  // Scan direction is fixed at start so a later mode change cannot switch the search
  always_ff @(posedge clock) begin
    if (rst) begin
      scan_tx_reg <= 1'b0;
    end else if (scan_start) begin
      scan_tx_reg <= (state_next == FMT_TX);
    end
  end

  fmt_scan_engine #(
    .CHW(CHW)
  ) u_fmt_scan_engine (
    .clock(clock),
    .rst(rst),
    .start(scan_start),
    .is_tx(scan_tx_reg),
    .tx_scan_threshold(thr_reg),
    .meas(meas),
    .probe_index(probe_index),
    .busy(scan_busy),
    .done(scan_done),
    .found(scan_found),
    .best_index(scan_index)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      tuned_frequency_index <= CHW'(`FMT_CHAN_RESET);
    end else if (scan_busy) begin
      tuned_frequency_index <= probe_index;
    end else if (mode_control_reg.scan_result_override) begin
      tuned_frequency_index <= chan_reg;
    end else begin
      tuned_frequency_index <= scan_index;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts: set wins over write-one-to-clear
  assign irq_events = {scan_done && scan_found, state_reg != state_d1_reg, scan_done};
  assign irq_pending = |(irq_stat_reg & irq_mask_reg);

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_stat_reg <= '0;
    end else begin
      if (wr_acc && paddr == `FMT_OFF_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~pwdata[`FMT_IRQ_W-1:0]) | irq_events;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_events;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_mask_reg <= '0;
    end else if (wr_acc && paddr == `FMT_OFF_IRQ_MASK) begin
      irq_mask_reg <= pwdata[`FMT_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_pending;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions: register bus and readback
  a_apb_answer: assert property (@(posedge clock) disable iff (rst)
    setup |=> pready) else $error("apb answer missing");
  a_apb_pulse: assert property (@(posedge clock) disable iff (rst)
    pready |=> !pready) else $error("apb answer too long");
  a_status_ro: assert property (@(posedge clock) disable iff (rst)
    (wr_acc && paddr == `FMT_OFF_STAT) |=> $stable(chan_reg) && $stable(thr_reg) && $stable(irq_mask_reg))
    else $error("status write changed a register");
  a_status_read: assert property (@(posedge clock) disable iff (rst)
    (setup && !pwrite && paddr == `FMT_OFF_STAT) |=> prdata[2:0] == $past(state_reg))
    else $error("status readback wrong");
  a_wo_read: assert property (@(posedge clock) disable iff (rst)
    (setup && !pwrite && paddr == `FMT_OFF_MODE) |=> prdata[7:0] == $past(mode_control_reg))
    else $error("mode readback wrong");
  a_wo_readback: assert property (@(posedge clock) disable iff (rst)
    (wr_acc && paddr == `FMT_OFF_MODE) |=> (mode_control_reg & `FMT_MODE_WO_MASK) == ($past(pwdata[7:0]) & `FMT_MODE_WO_MASK))
    else $error("write-only readback differs");
  a_mode_hold: assert property (@(posedge clock) disable iff (rst)
    (!(wr_acc && paddr == `FMT_OFF_MODE) && !scan_done) |=> $stable(mode_control_reg))
    else $error("mode register changed without cause");

  //////////////////////////////////////////////////////////////////////////////
  // Assertions: mode selection
  a_rx_priority: assert property (@(posedge clock) disable iff (rst)
    mode_control_reg.rx_req |=> rx_on && !tx_on && !standby_on) else $error("rx not prioritised");
  a_tx_mode: assert property (@(posedge clock) disable iff (rst)
    (mode_control_reg.tx_req && !mode_control_reg.rx_req) |=> tx_on) else $error("tx not entered");
  a_rx_priority_sm: assert property (@(posedge clock) disable iff (rst)
    (mode_control_reg.rx_req && mode_control_reg.tx_req) |=> state_reg == FMT_RX) else $error("priority wrong");
  a_idle_default: assert property (@(posedge clock) disable iff (rst)
    (!mode_control_reg.rx_req && !mode_control_reg.tx_req && !mode_control_reg.stnby_req) |=> !rx_on && !tx_on && !standby_on)
    else $error("idle not entered");
  a_standby_gate: assert property (@(posedge clock) disable iff (rst)
    $rose(standby_on) |-> $past(state_reg) == FMT_IDLE) else $error("standby entered from active mode");
  a_audio_route: assert property (@(posedge clock) disable iff (rst)
    rx_on |-> (rx_audio_digital != rx_audio_analog)) else $error("audio route wrong");
  a_audio_off: assert property (@(posedge clock) disable iff (rst)
    !rx_on |-> !rx_audio_digital && !rx_audio_analog) else $error("audio routed outside receive");

  //////////////////////////////////////////////////////////////////////////////
  // Assertions: scan
  a_scan_start: assert property (@(posedge clock) disable iff (rst)
    scan_start |=> scan_busy) else $error("scan did not start");
  a_scan_clear: assert property (@(posedge clock) disable iff (rst)
    (scan_done && !wr_acc) |=> !mode_control_reg.scan_en) else $error("scan enable not cleared");
  a_rx_stop_first: assert property (@(posedge clock) disable iff (rst)
    (scan_busy && !scan_tx_reg && meas.valid && meas.rssi != 8'h00) |=> !scan_busy && scan_found && scan_index == $past(probe_index))
    else $error("receive scan did not stop at first station");
  a_tx_scan_full: assert property (@(posedge clock) disable iff (rst)
    (scan_busy && scan_tx_reg && probe_index != CHW'(`FMT_CHAN_MAX)) |=> scan_busy)
    else $error("transmit scan ended early");
  a_chan_override: assert property (@(posedge clock) disable iff (rst)
    (!scan_busy && mode_control_reg.scan_result_override) |=> tuned_frequency_index == $past(chan_reg))
    else $error("host channel not used");
  a_tuned_scan: assert property (@(posedge clock) disable iff (rst)
    (!scan_busy && !mode_control_reg.scan_result_override) |=> tuned_frequency_index == $past(scan_index))
    else $error("scan channel not used");

  //////////////////////////////////////////////////////////////////////////////
  // Assertions: interrupts
  a_irq_set_wins: assert property (@(posedge clock) disable iff (rst)
    (irq_events != '0) |=> (irq_stat_reg & $past(irq_events)) == $past(irq_events))
    else $error("interrupt event lost");
  a_irq_level: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> irq == $past(irq_pending)) else $error("interrupt level wrong");

  c_rx_scan: cover property (@(posedge clock) disable iff (rst) scan_done && state_reg == FMT_RX);
  c_tx_scan: cover property (@(posedge clock) disable iff (rst) scan_done && state_reg == FMT_TX);
  c_standby: cover property (@(posedge clock) disable iff (rst) standby_on);
  c_irq: cover property (@(posedge clock) disable iff (rst) irq);
  c_rx_to_tx: cover property (@(posedge clock) disable iff (rst) state_reg == FMT_TX && state_d1_reg == FMT_RX);
endmodule // fmt_mode_ctrl

// [test_fmt_mode_ctrl.sv]
// Self-checking bench for the mode-control register block
`timescale 1ns/10ps
`include "fmt_regs.svh"
module test_fmt_mode_ctrl;
  import fmt_pkg::*;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] mask;
    logic err;
  } fmt_note_s;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  fmt_scan_s meas = '0;
  logic rx_on, tx_on, standby_on, rx_audio_digital, rx_audio_analog, irq;
  logic [9:0] tuned_frequency_index;
  logic [4:0] outs;
  logic [31:0] rd_data;
  logic [9:0] host;
  fmt_note_s notes[$];
  fmt_note_s n;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int k;
  assign outs = {rx_audio_digital, rx_audio_analog, standby_on, tx_on, rx_on};
  fmt_mode_ctrl #(.CHW(10)) u_fmt_mode_ctrl (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas(meas), .rx_on(rx_on), .tx_on(tx_on), .standby_on(standby_on), .rx_audio_digital(rx_audio_digital),
    .rx_audio_analog(rx_audio_analog), .tuned_frequency_index(tuned_frequency_index), .irq(irq));
  always #10 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////////
  // Closing report and timeout
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      end_sim();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Monitor takes the oldest note at each completed transfer
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1) begin
      n = notes.pop_front();
      check_count++;
      if (((prdata & n.mask) !== n.exp) || (pslverr !== n.err)) begin
        num_errors++;
        $display("MISMATCH t=%0t got %h/%h exp %h/%h", $time, prdata & n.mask, pslverr, n.exp, n.err);
      end
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Bus tasks
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, input logic err);
    notes.push_back('{e, m, err});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd_data = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, e, m, 1'b0);
  endtask
  task automatic setm(input logic [7:0] v, input logic [4:0] e);
    wr(`FMT_OFF_MODE, {24'h0, v});
    repeat (2) @(posedge clock);
    rd(`FMT_OFF_MODE, {24'h0, v & 8'hdf}, 32'hdf);
    chk({27'h0, outs}, {27'h0, e});
  endtask
  task automatic scan(input int kk, input logic tx, input logic [7:0] after);
    int t;
    repeat (4) @(posedge clock);
    for (int i = 0; i <= (tx ? 1023 : kk); i++) begin
      meas <= '{1'b1, 10'(i), (i == kk) ? (tx ? 8'h01 : 8'h40) : (tx ? 8'(8'h10 + $urandom_range(0, 200)) : 8'h00)};
      @(posedge clock);
      meas.valid <= 1'b0;
      repeat (2) @(posedge clock);
    end
    t = 0;
    rd_data = 32'h20;
    while (rd_data[5] === 1'b1 && t < 20) begin
      apb(1'b0, `FMT_OFF_MODE, 32'h0, 32'h0, 32'h0, 1'b0);
      t++;
    end
    rd(`FMT_OFF_MODE, {24'h0, after}, 32'hff);
    chk({22'h0, tuned_frequency_index}, kk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    k = $urandom(32'h41ae4717);
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(`FMT_OFF_MODE, 32'h01, 32'hff);
    chk({27'h0, outs}, 32'h0);
    setm(8'hd1, 5'b01001);
    setm(8'h89, 5'b10001);
    setm(8'h51, 5'b00010);
    setm(8'h01, 5'b00000);
    setm(8'h11, 5'b00100);
    wr(`FMT_OFF_STAT, 32'hffffffff);
    rd(`FMT_OFF_STAT, 32'h1, 32'h7);
    apb(1'b0, 12'h020, 32'h0, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b1, 12'h024, 32'hffffffff, 32'h0, 32'h0, 1'b1);
    host = 10'($urandom);
    wr(`FMT_OFF_CHAN, {22'h0, host});
    setm(8'h81, 5'b01001);
    chk({22'h0, tuned_frequency_index}, {22'h0, host});
    k = $urandom_range(1, 40);
    wr(`FMT_OFF_MODE, 32'ha0);
    scan(k, 1'b0, 8'h80);
    wr(`FMT_OFF_IRQ_STAT, 32'h6);
    chk({31'h0, irq}, 32'h0);
    rd(`FMT_OFF_IRQ_STAT, 32'h1, 32'h1);
    wr(`FMT_OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    wr(`FMT_OFF_IRQ_STAT, 32'h7);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    k = $urandom_range(0, 1023);
    wr(`FMT_OFF_CHAN, 32'h0);
    wr(`FMT_OFF_MODE, 32'h60);
    scan(k, 1'b1, 8'h40);
    end_sim();
  end
endmodule // test_fmt_mode_ctrl
